// ---- rtl/sgsr_pkg.sv ----
package sgsr_pkg;

	// -----------------------------------------------------------------
	// register offsets (byte addresses)
	// -----------------------------------------------------------------
	localparam logic [11:0] SGSR_OFF_SRST0 = 12'h040;
	localparam logic [11:0] SGSR_OFF_SRST1 = 12'h044;
	localparam logic [11:0] SGSR_OFF_GATE = 12'h128;
	localparam logic [11:0] SGSR_OFF_IRQ_STAT = 12'h150;
	localparam logic [11:0] SGSR_OFF_IRQ_MASK = 12'h154;

	// -----------------------------------------------------------------
	// field layout and reset values
	// -----------------------------------------------------------------
	localparam int SGSR_NUM_PORTS = 5;
	localparam logic [31:0] SGSR_SRST0_RESET = 32'h00000000;
	localparam logic [31:0] SGSR_SRST1_RESET = 32'h00000000;
	localparam logic [31:0] SGSR_GATE_RESET = 32'h00000000;
	localparam int SGSR_BIT_COMPARATOR_ZERO_RESET = 24;
	localparam int SGSR_BIT_TMR2 = 18;
	localparam int SGSR_BIT_TMR1 = 17;
	localparam int SGSR_BIT_TMR0 = 16;
	localparam int SGSR_BIT_SYNC_SERIAL_ZERO_RESET = 4;
	localparam int SGSR_BIT_ASYNC_SERIAL_ONE_RESET = 1;
	localparam int SGSR_BIT_ASYNC_SERIAL_ZERO_RESET = 0;
	// writable bits of the second soft reset register
	localparam logic [31:0] SGSR_SRST1_WMASK = (32'h1 << SGSR_BIT_COMPARATOR_ZERO_RESET)
		| (32'h1 << SGSR_BIT_TMR2) | (32'h1 << SGSR_BIT_TMR1)
		| (32'h1 << SGSR_BIT_TMR0) | (32'h1 << SGSR_BIT_SYNC_SERIAL_ZERO_RESET)
		| (32'h1 << SGSR_BIT_ASYNC_SERIAL_ONE_RESET) | (32'h1 << SGSR_BIT_ASYNC_SERIAL_ZERO_RESET);
	localparam logic [31:0] SGSR_ZERO_WORD = 32'h00000000;

endpackage : sgsr_pkg

// ---- rtl/sgsr_gating_soft_reset.sv ----
// How it works
// - gate bit one in deep sleep: the port clock enable is on.
// - gate bit zero in deep sleep: port clock stops, port disabled.
// - an access to an unclocked port gives a bus fault, not completion.
// - gate register holds one read-write bit per port, reset zero.
// - soft reset 0 at 0x040, writes masked by capability mask 1.
// - soft reset 1 at 0x044, writes masked by capability mask 2.
// - soft reset 1 resets zero; only listed unit bits writable.
// - gate bits act only in deep sleep; run gating is separate.
// - each writable soft reset 1 bit drives its unit's reset.
`timescale 1ns/1ps

module sgsr_gating_soft_reset #(
	parameter int NUM_PORTS = sgsr_pkg::SGSR_NUM_PORTS
) (
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// capability masks and power mode
	input wire logic [31:0] capability_mask_1,
	input wire logic [31:0] capability_mask_2,
	input wire logic deep_sleep,
	input wire logic [NUM_PORTS-1:0] run_clk_gate,
	// port clocking and access checking
	input wire logic [NUM_PORTS-1:0] port_access,
	output logic [NUM_PORTS-1:0] port_clk_en,
	output logic [NUM_PORTS-1:0] port_access_ok,
	output logic bus_fault,
	// peripheral resets and interrupt
	output logic [31:0] periph_reset_0,
	output logic [31:0] periph_reset_1,
	output logic irq
);
	import sgsr_pkg::*;

	// elaboration guard: the 32-bit register views need 1..32 ports
	if (NUM_PORTS < 1 || NUM_PORTS > 32) begin : g_bad_ports
		$error("NUM_PORTS must lie in 1..32");
	end

	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	logic [NUM_PORTS-1:0] gate_reg, gate_next;
	logic [31:0] srst0_reg, srst0_next;
	logic [31:0] srst1_reg, srst1_next;
	logic [NUM_PORTS-1:0] stat_reg, stat_next;
	logic [NUM_PORTS-1:0] mask_reg, mask_next;
	logic [NUM_PORTS-1:0] clk_en_reg, clk_en_next;
	logic [NUM_PORTS-1:0] ok_reg, ok_next;
	logic fault_reg, fault_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	logic irq_reg, irq_next;
	logic done;
	logic wr_done;
	logic mapped;
	logic [NUM_PORTS-1:0] fault_vec;
	logic [31:0] gate_word, stat_word, mask_word;

	// -----------------------------------------------------------------
	// next-state logic
	// -----------------------------------------------------------------
	// zero-extended views for the read mux
	always_comb begin
		gate_word = SGSR_ZERO_WORD;
		stat_word = SGSR_ZERO_WORD;
		mask_word = SGSR_ZERO_WORD;
		gate_word[NUM_PORTS-1:0] = gate_reg;
		stat_word[NUM_PORTS-1:0] = stat_reg;
		mask_word[NUM_PORTS-1:0] = mask_reg;
	end

	// apb decode; one wait state keeps every bus output a flop
	always_comb begin
		done = psel && penable && pready_reg;
		wr_done = done && pwrite;
		mapped = (paddr == SGSR_OFF_SRST0) || (paddr == SGSR_OFF_SRST1)
			|| (paddr == SGSR_OFF_GATE) || (paddr == SGSR_OFF_IRQ_STAT)
			|| (paddr == SGSR_OFF_IRQ_MASK);
		pready_next = psel && penable && !pready_reg;
		pslverr_next = pready_next && !mapped;
		prdata_next = SGSR_ZERO_WORD;
		if (pready_next && !pwrite) begin
			unique case (paddr)
				SGSR_OFF_SRST0: prdata_next = srst0_reg;
				SGSR_OFF_SRST1: prdata_next = srst1_reg;
				SGSR_OFF_GATE: prdata_next = gate_word;
				SGSR_OFF_IRQ_STAT: prdata_next = stat_word;
				SGSR_OFF_IRQ_MASK: prdata_next = mask_word;
				default: prdata_next = SGSR_ZERO_WORD;
			endcase
		end
	end

	// register writes; soft reset bits hold until software clears them
	always_comb begin
		gate_next = gate_reg;
		srst0_next = srst0_reg;
		srst1_next = srst1_reg;
		mask_next = mask_reg;
		if (wr_done) begin
			if (paddr == SGSR_OFF_GATE) begin
				gate_next = pwdata[NUM_PORTS-1:0];
			end
			if (paddr == SGSR_OFF_SRST0) begin
				srst0_next = pwdata & capability_mask_1;
			end
			if (paddr == SGSR_OFF_SRST1) begin
				srst1_next = pwdata & capability_mask_2 & SGSR_SRST1_WMASK;
			end
			if (paddr == SGSR_OFF_IRQ_MASK) begin
				mask_next = pwdata[NUM_PORTS-1:0];
			end
		end
	end

	// clock enables: gate bits matter only in deep sleep
	always_comb begin
		if (deep_sleep) begin
			clk_en_next = gate_reg;
		end else begin
			clk_en_next = run_clk_gate;
		end
	end

	// access check against the clock actually delivered now
	always_comb begin
		fault_vec = port_access & ~clk_en_reg;
		ok_next = port_access & clk_en_reg;
		fault_next = |fault_vec;
	end

	// sticky per-port fault status; a new fault beats a w1c clear
	always_comb begin
		stat_next = stat_reg;
		if (wr_done && paddr == SGSR_OFF_IRQ_STAT) begin
			stat_next = stat_reg & ~pwdata[NUM_PORTS-1:0];
		end
		stat_next = stat_next | fault_vec;
		irq_next = |(stat_next & mask_next);
	end

	// -----------------------------------------------------------------
	// registers
	// -----------------------------------------------------------------
	// all state, constant reset values only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_reg <= SGSR_GATE_RESET[NUM_PORTS-1:0];
			srst0_reg <= SGSR_SRST0_RESET;
			srst1_reg <= SGSR_SRST1_RESET;
			stat_reg <= '0;
			mask_reg <= '0;
			clk_en_reg <= '0;
			ok_reg <= '0;
			fault_reg <= 1'b0;
			prdata_reg <= SGSR_ZERO_WORD;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			gate_reg <= gate_next;
			srst0_reg <= srst0_next;
			srst1_reg <= srst1_next;
			stat_reg <= stat_next;
			mask_reg <= mask_next;
			clk_en_reg <= clk_en_next;
			ok_reg <= ok_next;
			fault_reg <= fault_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			irq_reg <= irq_next;
		end
	end

	// outputs straight from flops; reset bits drive units directly
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign port_clk_en = clk_en_reg;
	assign port_access_ok = ok_reg;
	assign bus_fault = fault_reg;
	assign periph_reset_0 = srst0_reg;
	assign periph_reset_1 = srst1_reg;
	assign irq = irq_reg;

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	gate_on_a: assert property (@(posedge pclk) disable iff (!presetn)
		deep_sleep |=> ((port_clk_en & $past(gate_reg)) == $past(gate_reg)))
		else $error("gated-on port lacks clock in deep sleep");

	gate_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		deep_sleep |=> ((port_clk_en & ~$past(gate_reg)) == '0))
		else $error("gated-off port still clocked in deep sleep");

	access_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
		(|(port_access & ~port_clk_en)) |=> bus_fault
			&& ((port_access_ok & ~$past(port_clk_en)) == '0))
		else $error("unclocked port access did not fault");

	gate_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && pready && pwrite && paddr == SGSR_OFF_GATE)
			|=> gate_reg == $past(pwdata[NUM_PORTS-1:0]))
		else $error("gate register write lost");

	srst0_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && pready && pwrite && paddr == SGSR_OFF_SRST0)
			|=> periph_reset_0 == ($past(pwdata) & $past(capability_mask_1)))
		else $error("soft reset 0 not masked by capability");

	srst1_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && pready && pwrite && paddr == SGSR_OFF_SRST1)
			|=> periph_reset_1 == ($past(pwdata) & $past(capability_mask_2)
				& SGSR_SRST1_WMASK))
		else $error("soft reset 1 not masked by capability");

	srst1_rsvd_a: assert property (@(posedge pclk) disable iff (!presetn)
		(periph_reset_1 & ~SGSR_SRST1_WMASK) == SGSR_ZERO_WORD)
		else $error("reserved soft reset 1 bit set");

	run_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		!deep_sleep |=> port_clk_en == $past(run_clk_gate))
		else $error("run gating not followed outside deep sleep");

	comp_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && pready && pwrite && paddr == SGSR_OFF_SRST1
			&& capability_mask_2[SGSR_BIT_COMPARATOR_ZERO_RESET] && pwdata[SGSR_BIT_COMPARATOR_ZERO_RESET])
			|=> periph_reset_1[SGSR_BIT_COMPARATOR_ZERO_RESET])
		else $error("comparator reset not asserted");

	reset_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(psel && penable && pready && pwrite) |=> $stable(periph_reset_1)
			&& $stable(periph_reset_0))
		else $error("peripheral reset changed without a write");

	irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
		(|(stat_reg & mask_reg)) |-> irq)
		else $error("interrupt low with unmasked status");

	irq_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(|(stat_reg & mask_reg)) |-> !irq)
		else $error("interrupt high with no unmasked status");

	// bus handshake: one wait state, single-cycle answer
	ready_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && !pready) |=> pready)
		else $error("access phase not answered after one wait");

	ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("ready held for more than one cycle");

	slverr_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready)
		else $error("slave error without ready");

	// port access answers, judged against the enable of the access cycle
	access_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
		(|(port_access & port_clk_en))
			|=> port_access_ok == ($past(port_access) & $past(port_clk_en)))
		else $error("clocked port access did not complete");

	fault_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(|(port_access & ~port_clk_en)) |=> !bus_fault)
		else $error("bus fault without an unclocked access");

	fault_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
		(|(port_access & ~port_clk_en))
			|=> (stat_reg & $past(port_access) & ~$past(port_clk_en))
				== ($past(port_access) & ~$past(port_clk_en)))
		else $error("fault status bit not set");

	// register read-back, reserved bits zero
	gate_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && !pready && !pwrite && paddr == SGSR_OFF_GATE)
			|=> prdata[NUM_PORTS-1:0] == $past(gate_reg)
				&& (prdata >> NUM_PORTS) == SGSR_ZERO_WORD)
		else $error("gate register read mismatch");

	srst0_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && !pready && !pwrite && paddr == SGSR_OFF_SRST0)
			|=> prdata == $past(periph_reset_0))
		else $error("soft reset 0 read mismatch");

	srst1_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && !pready && !pwrite && paddr == SGSR_OFF_SRST1)
			|=> prdata == $past(periph_reset_1))
		else $error("soft reset 1 read mismatch");

endmodule : sgsr_gating_soft_reset

// ---- testbench/sgsr_core_model.sv ----
`timescale 1ns/1ps

// -----------------------------------------------------------------
// core side: issues port access strobes, collects the answers
// -----------------------------------------------------------------
module sgsr_core_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// port access strobes and answers
	output logic [4:0] port_access,
	input wire logic [4:0] port_access_ok,
	input wire logic bus_fault
);
	initial port_access = 5'h00;

	// one-cycle strobe, answer looked at mid-cycle to dodge edge races
	task access(input logic [4:0] m, output logic [4:0] ok,
		output logic f);
		wait (presetn === 1'b1);
		@(posedge pclk);
		port_access <= m;
		@(posedge pclk);
		port_access <= 5'h00;
		@(negedge pclk);
		ok = port_access_ok;
		f = bus_fault;
	endtask : access
endmodule : sgsr_core_model

// ---- testbench/sgsr_gating_soft_reset_tb.sv ----
`timescale 1ns/1ps

module sgsr_gating_soft_reset_tb;
	import sgsr_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic deep_sleep = 1'b1;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] cap1 = 32'h00FF00F0;
	logic [31:0] cap2 = 32'hFFFDFFFF;
	logic [4:0] run_gate = 5'h00;
	logic pready, pslverr, bus_fault, irq, err, f;
	logic [31:0] prdata, rd, rst0, rst1;
	logic [4:0] port_access, clk_en, acc_ok, ok;
	int failures = 0;
	int n_compared = 0;
	int cycles = 0;

	sgsr_gating_soft_reset uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.capability_mask_1(cap1), .capability_mask_2(cap2),
		.deep_sleep(deep_sleep), .run_clk_gate(run_gate),
		.port_access(port_access), .port_clk_en(clk_en),
		.port_access_ok(acc_ok), .bus_fault(bus_fault),
		.periph_reset_0(rst0), .periph_reset_1(rst1), .irq(irq));
	sgsr_core_model core (.pclk(pclk), .presetn(presetn),
		.port_access(port_access), .port_access_ok(acc_ok),
		.bus_fault(bus_fault));

	// -----------------------------------------------------------------
	// clock, hang guard, shared tasks
	// -----------------------------------------------------------------
	initial begin
		forever #20 pclk = ~pclk;
	end

	// a hang cannot pass: whole run needs well under 2000 cycles
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			end_of_test();
		end
	end

	task end_of_test();
		if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_of_test

	task chk(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// request held until pready is seen high at a rising edge; a hang
	// is left to the cycle guard
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// -----------------------------------------------------------------
	// scenarios
	// -----------------------------------------------------------------
	task t_gate();
		apb(1'b0, SGSR_OFF_GATE, 32'h0);
		chk("gate reset", 32'h0, rd);
		chk("clk_en reset", 32'h0, clk_en);
		apb(1'b1, SGSR_OFF_GATE, 32'hFFFFFFFF);
		apb(1'b0, SGSR_OFF_GATE, 32'h0);
		chk("gate all ones", 32'h1F, rd);
		apb(1'b1, SGSR_OFF_GATE, 32'h15);
		repeat (2) @(posedge pclk);
		chk("clk_en deep", 32'h15, clk_en);
		deep_sleep <= 1'b0;
		run_gate <= 5'h0A;
		repeat (3) @(posedge pclk);
		chk("clk_en run", 32'h0A, clk_en);
		deep_sleep <= 1'b1;
		repeat (3) @(posedge pclk);
	endtask : t_gate

	task t_fault();
		apb(1'b1, SGSR_OFF_IRQ_MASK, 32'h2);
		core.access(5'h03, ok, f);
		chk("access ok", 32'h01, ok);
		chk("fault", 32'h1, f);
		apb(1'b0, SGSR_OFF_IRQ_STAT, 32'h0);
		chk("status", 32'h2, rd);
		chk("irq set", 32'h1, irq);
		apb(1'b1, SGSR_OFF_IRQ_STAT, 32'h2);
		apb(1'b0, SGSR_OFF_IRQ_STAT, 32'h0);
		chk("status clear", 32'h0, rd);
		chk("irq clear", 32'h0, irq);
	endtask : t_fault

	task t_srst();
		apb(1'b0, SGSR_OFF_SRST1, 32'h0);
		chk("srst1 reset", 32'h0, rd);
		apb(1'b1, SGSR_OFF_SRST0, 32'hFFFFFFFF);
		apb(1'b0, SGSR_OFF_SRST0, 32'h0);
		chk("srst0 masked", cap1, rd);
		chk("reset out 0", cap1, rst0);
		apb(1'b1, SGSR_OFF_SRST1, 32'hFFFFFFFF);
		apb(1'b0, SGSR_OFF_SRST1, 32'h0);
		chk("srst1 masked", SGSR_SRST1_WMASK & cap2, rd);
		chk("comp reset", 32'h1, rst1[SGSR_BIT_COMPARATOR_ZERO_RESET]);
		apb(1'b1, SGSR_OFF_SRST1, 32'h0);
		apb(1'b1, SGSR_OFF_SRST0, 32'h0);
		@(posedge pclk);
		chk("release 1", 32'h0, rst1);
		chk("release 0", 32'h0, rst0);
		apb(1'b1, 12'h100, 32'hFFFFFFFF);
		chk("unmapped wr err", 32'h1, err);
		apb(1'b0, 12'h100, 32'h0);
		chk("unmapped rd", 32'h0, rd);
		chk("unmapped rd err", 32'h1, err);
	endtask : t_srst

	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_gate();
		t_fault();
		t_srst();
		end_of_test();
	end
endmodule : sgsr_gating_soft_reset_tb
